// [rtl/bbs_params.svh]
/*
  constants for the bit, branch and subtract execution block: reset values,
  cleared values and operand field widths.
  assumes it is included by bare name from the package and the design files.
*/
`ifndef BBS_PARAMS_SVH
`define BBS_PARAMS_SVH

// operand field widths
`define BBS_DATA_W 8
`define BBS_FADDR_W 7
`define BBS_BIT_W 3
`define BBS_LIT_W 9

// reset values of core state
`define BBS_ACC_RST 8'h00
`define BBS_PC_RST 15'h0000
`define BBS_BORROW_RST 1'b0
`define BBS_NIBBLE_RST 1'b0
`define BBS_ZERO_RST 1'b0

// power-down side effects: counter and prescaler cleared, flag levels
`define BBS_WDT_CLR 8'h00
`define BBS_PRE_CLR 8'h00
`define BBS_EXPIRY_SET 1'b1
`define BBS_SLEEP_CLR 1'b0
`define BBS_FLAG_RST 1'b1

// plain subtract enters the adder with no borrow pending
`define BBS_NO_BORROW 1'b1

`endif

// [rtl/bbs_pkg.sv]
/*
  types of the bit, branch and subtract execution block.
  assumes the params header sits on the include path.
*/
`include "bbs_params.svh"

package bbs_pkg;
  // decoded instruction, one-hot
  typedef enum logic [11:0] {
    BBS_OP_IDLE  = 12'h001,
    BBS_OP_BCLR  = 12'h002,
    BBS_OP_BSET  = 12'h004,
    BBS_OP_SKZ   = 12'h008,
    BBS_OP_SKO   = 12'h010,
    BBS_OP_RJMP  = 12'h020,
    BBS_OP_AJMP  = 12'h040,
    BBS_OP_RRC   = 12'h080,
    BBS_OP_LSUB  = 12'h100,
    BBS_OP_RSUB  = 12'h200,
    BBS_OP_RSUBB = 12'h400,
    BBS_OP_SLEEP = 12'h800
  } bbs_op_t;

  // execution sequencer, one-hot
  typedef enum logic [2:0] {
    BBS_ST_EXEC = 3'h1,
    BBS_ST_SKIP = 3'h2,
    BBS_ST_JUMP = 3'h4
  } bbs_state_t;
endpackage

// [rtl/bbs_alu_if.sv]
/*
  interface between the execution core and its subtract/rotate datapath.
  assumes both ends run in the single core clock domain; no state inside.
*/
`timescale 1ns/1ps

interface bbs_alu_if;
  logic [7:0] opnd;  // register value or literal
  logic [7:0] acc;   // accumulator
  logic cin;         // borrow-inverse bit entering the operation
  logic rot;         // rotate instead of subtract
  logic [7:0] res;   // result
  logic c_out;       // new borrow-inverse bit
  logic dc_out;      // new nibble bit
  logic z_out;       // result is zero

  modport core(output opnd, acc, cin, rot, input res, c_out, dc_out, z_out);
  modport alu(input opnd, acc, cin, rot, output res, c_out, dc_out, z_out);
endinterface

// [rtl/bbs_alu.sv]
/*
  combinational subtract and rotate datapath of the execution block.
  assumes the core holds all state and registers every result.
*/
`timescale 1ns/1ps

module bbs_alu (
  // operands in, results out
  bbs_alu_if.alu bus
);
  logic [8:0] full_sum; // opnd + ~acc + cin, bit 8 is no-borrow
  logic [4:0] low_sum;  // same on the low nibble only

  //////////////////////////////////////////////////////////////////////////
  // two's complement subtract: adding the inverse avoids a second adder
  assign full_sum = {1'b0, bus.opnd} + {1'b0, ~bus.acc} + {8'h00, bus.cin};
  assign low_sum = {1'b0, bus.opnd[3:0]} + {1'b0, ~bus.acc[3:0]} + {4'h0, bus.cin};

  // result select and status
  always_comb begin
    if (bus.rot) begin
      // old flag enters bit 7, old bit 0 leaves into the flag
      bus.res = {bus.cin, bus.opnd[7:1]};
      bus.c_out = bus.opnd[0];
      bus.dc_out = 1'b0;
    end else begin
      bus.res = full_sum[7:0];
      bus.c_out = full_sum[8];
      bus.dc_out = low_sum[4];
    end
    bus.z_out = (bus.res == 8'h00);
  end
endmodule

// [rtl/bbs_exec.sv]
/*
  execution core for bit clear/set/test, relative jumps, rotate through the
  borrow-inverse bit, three subtracts and the power-down side effects.
  assumes the fetch path presents one decoded instruction with instr_valid_i
  and the register file presents the addressed register on rf_rdata_i in
  that same cycle; writes come back one cycle later on the rf_* outputs.
*/
`timescale 1ns/1ps
`include "bbs_params.svh"

// Behaviour
// - bit clear zeroes one register bit, flags kept
// - bit set forces one register bit, flags kept
// - skip on zero bit: idle slot, two cycles
// - skip on one bit: idle slot, two cycles
// - relative jump to pc plus one plus k
// - accumulator jump to pc plus one plus acc
// - rotate right through the borrow-inverse bit
// - destination 0 accumulator, 1 source register
// - literal minus accumulator into the accumulator
// - register minus accumulator, borrow and nibble flags
// - subtract with borrow uses the inverted flag
// - power-down clears watchdog, sets expiry, clears sleep
module bbs_exec import bbs_pkg::*; #(
  parameter int PC_W = 15,  // program counter width
  parameter int PRE_W = 8   // watchdog prescaler width
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // decoded instruction from fetch
  input wire logic instr_valid_i,
  input wire bbs_op_t op_i,
  input wire logic [`BBS_FADDR_W-1:0] faddr_i,
  input wire logic [`BBS_BIT_W-1:0] bit_i,
  input wire logic dest_i,
  input wire logic [`BBS_LIT_W-1:0] lit_i,
  // register file
  input wire logic [`BBS_DATA_W-1:0] rf_rdata_i,
  output logic rf_we_o,
  output logic [`BBS_FADDR_W-1:0] rf_addr_o,
  output logic [`BBS_DATA_W-1:0] rf_wdata_o,
  // core state
  output logic [PC_W-1:0] pc_o,
  output logic idle_slot_o,
  output logic [`BBS_DATA_W-1:0] acc_o,
  output logic borrow_o,
  output logic nibble_o,
  output logic zero_o,
  // watchdog and power status
  output logic [7:0] wdt_count_o,
  output logic expiry_flag_o,
  output logic sleep_flag_o
);
  logic rst_s1_r, rst_n_r;            // reset release synchroniser
  bbs_state_t state_r, state_nxt;     // sequencer
  logic [PC_W-1:0] pc_r, pc_nxt;      // address of current instruction
  logic [7:0] acc_r, acc_nxt;         // accumulator
  logic borrow_r, borrow_nxt;         // borrow-inverse bit
  logic nibble_r, nibble_nxt;         // nibble half bit
  logic zero_r, zero_nxt;             // null result bit
  logic we_r, we_nxt;                 // register write strobe
  logic [6:0] waddr_r, waddr_nxt;     // register write address
  logic [7:0] wdata_r, wdata_nxt;     // register write data
  logic idle_r, idle_nxt;             // current slot is discarded
  logic [7:0] wdt_r, wdt_nxt;         // watchdog counter
  logic [PRE_W-1:0] pre_r, pre_nxt;   // watchdog prescaler
  logic expiry_r, expiry_nxt;         // expiry flag
  logic sleep_r, sleep_nxt;           // sleep flag
  logic take;                         // instruction accepted this cycle
  logic tbit;                         // tested register bit
  logic [7:0] bmask;                  // one-hot mask of the selected bit

  bbs_alu_if alu_bus ();

  bbs_alu u_alu (
    .bus(alu_bus)
  );

  //////////////////////////////////////////////////////////////////////////
  // reset: asserted at once, released through two flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // operand steering into the datapath
  assign take = instr_valid_i && (state_r == BBS_ST_EXEC);
  assign tbit = rf_rdata_i[bit_i];
  assign bmask = 8'h01 << bit_i;
  assign alu_bus.opnd = (op_i == BBS_OP_LSUB) ? lit_i[7:0] : rf_rdata_i;
  assign alu_bus.acc = acc_r;
  // only the borrowing forms and the rotate see the stored flag
  assign alu_bus.cin = (op_i == BBS_OP_RSUBB || op_i == BBS_OP_RRC) ?
                       borrow_r : `BBS_NO_BORROW;
  assign alu_bus.rot = (op_i == BBS_OP_RRC);

  //////////////////////////////////////////////////////////////////////////
  // next-state of the whole core
  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    acc_nxt = acc_r;
    borrow_nxt = borrow_r;
    nibble_nxt = nibble_r;
    zero_nxt = zero_r;
    we_nxt = 1'b0;
    waddr_nxt = faddr_i;
    wdata_nxt = wdata_r;
    idle_nxt = 1'b0;
    expiry_nxt = expiry_r;
    sleep_nxt = sleep_r;
    // watchdog runs free; its overflow drops the expiry flag
    pre_nxt = pre_r + 1'b1;
    wdt_nxt = wdt_r;
    if (&pre_r) begin
      wdt_nxt = wdt_r + 8'h01;
      if (&wdt_r) begin
        expiry_nxt = 1'b0;
      end
    end
    unique case (state_r)
      BBS_ST_SKIP: begin
        // discarded instruction still consumed its address
        pc_nxt = pc_r + 1'b1;
        state_nxt = BBS_ST_EXEC;
      end
      BBS_ST_JUMP: begin
        // target already loaded; this slot is the refetch bubble
        state_nxt = BBS_ST_EXEC;
      end
      BBS_ST_EXEC: begin
        if (take) begin
          pc_nxt = pc_r + 1'b1;
          unique case (op_i)
            BBS_OP_BCLR: begin
              we_nxt = 1'b1;
              wdata_nxt = rf_rdata_i & ~bmask;
            end
            BBS_OP_BSET: begin
              we_nxt = 1'b1;
              wdata_nxt = rf_rdata_i | bmask;
            end
            BBS_OP_SKZ, BBS_OP_SKO: begin
              if (tbit == (op_i == BBS_OP_SKO)) begin
                state_nxt = BBS_ST_SKIP;
                idle_nxt = 1'b1;
              end
            end
            BBS_OP_RJMP: begin
              // signed 9-bit offset reaches -256..255
              pc_nxt = pc_r + 1'b1 + {{(PC_W-9){lit_i[8]}}, lit_i};
              state_nxt = BBS_ST_JUMP;
              idle_nxt = 1'b1;
            end
            BBS_OP_AJMP: begin
              pc_nxt = pc_r + 1'b1 + {{(PC_W-8){1'b0}}, acc_r};
              state_nxt = BBS_ST_JUMP;
              idle_nxt = 1'b1;
            end
            BBS_OP_RRC, BBS_OP_RSUB, BBS_OP_RSUBB: begin
              borrow_nxt = alu_bus.c_out;
              if (op_i != BBS_OP_RRC) begin
                nibble_nxt = alu_bus.dc_out;
                zero_nxt = alu_bus.z_out;
              end
              if (dest_i) begin
                we_nxt = 1'b1;
                wdata_nxt = alu_bus.res;
              end else begin
                acc_nxt = alu_bus.res;
              end
            end
            BBS_OP_LSUB: begin
              acc_nxt = alu_bus.res;
              borrow_nxt = alu_bus.c_out;
              nibble_nxt = alu_bus.dc_out;
              zero_nxt = alu_bus.z_out;
            end
            BBS_OP_SLEEP: begin
              wdt_nxt = `BBS_WDT_CLR;
              pre_nxt = PRE_W'(`BBS_PRE_CLR);
              expiry_nxt = `BBS_EXPIRY_SET;
              sleep_nxt = `BBS_SLEEP_CLR;
            end
            default: begin
              // idle or an illegal code: just advance
            end
          endcase
        end
      end
    endcase
  end

  // registers of the core
  always_ff @(posedge clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= BBS_ST_EXEC;
      pc_r <= PC_W'(`BBS_PC_RST);
      acc_r <= `BBS_ACC_RST;
      borrow_r <= `BBS_BORROW_RST;
      nibble_r <= `BBS_NIBBLE_RST;
      zero_r <= `BBS_ZERO_RST;
      we_r <= 1'b0;
      waddr_r <= 7'h00;
      wdata_r <= 8'h00;
      idle_r <= 1'b0;
      wdt_r <= `BBS_WDT_CLR;
      pre_r <= PRE_W'(`BBS_PRE_CLR);
      expiry_r <= `BBS_FLAG_RST;
      sleep_r <= `BBS_FLAG_RST;
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      acc_r <= acc_nxt;
      borrow_r <= borrow_nxt;
      nibble_r <= nibble_nxt;
      zero_r <= zero_nxt;
      we_r <= we_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      idle_r <= idle_nxt;
      wdt_r <= wdt_nxt;
      pre_r <= pre_nxt;
      expiry_r <= expiry_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  // outputs straight from flops
  assign rf_we_o = we_r;
  assign rf_addr_o = waddr_r;
  assign rf_wdata_o = wdata_r;
  assign pc_o = pc_r;
  assign idle_slot_o = idle_r;
  assign acc_o = acc_r;
  assign borrow_o = borrow_r;
  assign nibble_o = nibble_r;
  assign zero_o = zero_r;
  assign wdt_count_o = wdt_r;
  assign expiry_flag_o = expiry_r;
  assign sleep_flag_o = sleep_r;

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_r);

  bit_clear_a: assert property (take && op_i == BBS_OP_BCLR |=> rf_we_o &&
    rf_wdata_o == ($past(rf_rdata_i) & ~$past(bmask)) && $stable(borrow_o) && $stable(zero_o))
    else $error("bit clear wrong");
  bit_set_a: assert property (take && op_i == BBS_OP_BSET |=> rf_we_o &&
    rf_wdata_o == ($past(rf_rdata_i) | $past(bmask)) && $stable(nibble_o))
    else $error("bit set wrong");
  skip_zero_a: assert property (take && op_i == BBS_OP_SKZ && !tbit |=>
    idle_slot_o ##1 !idle_slot_o && pc_o == $past(pc_o, 2) + 2'd2)
    else $error("skip on zero wrong");
  skip_one_a: assert property (take && op_i == BBS_OP_SKO |=>
    idle_slot_o == $past(tbit))
    else $error("skip on one wrong");
  rel_jump_a: assert property (take && op_i == BBS_OP_RJMP |=> idle_slot_o &&
    pc_o == PC_W'($past(pc_o) + 1 + {{(PC_W-9){$past(lit_i[8])}}, $past(lit_i)}))
    else $error("relative jump target wrong");
  acc_jump_a: assert property (take && op_i == BBS_OP_AJMP |=>
    pc_o == PC_W'($past(pc_o) + 1 + $past(acc_o)) ##1 !idle_slot_o)
    else $error("accumulator jump target wrong");
  rotate_a: assert property (take && op_i == BBS_OP_RRC && !dest_i |=>
    {acc_o, borrow_o} == {$past(borrow_o), $past(rf_rdata_i)})
    else $error("rotate wrong");
  dest_sel_a: assert property (take && op_i == BBS_OP_RSUB |=>
    rf_we_o == $past(dest_i) && rf_addr_o == $past(faddr_i) &&
    (rf_we_o ? $stable(acc_o) && rf_wdata_o == 8'($past(rf_rdata_i) - $past(acc_o)) :
    acc_o == 8'($past(rf_rdata_i) - $past(acc_o))))
    else $error("destination select wrong");
  lit_sub_a: assert property (take && op_i == BBS_OP_LSUB |=>
    acc_o == 8'($past(lit_i[7:0]) - $past(acc_o)) &&
    borrow_o == ($past(acc_o) <= $past(lit_i[7:0])))
    else $error("literal subtract wrong");
  sub_flags_a: assert property (take && op_i == BBS_OP_RSUB |=>
    borrow_o == ($past(acc_o) <= $past(rf_rdata_i)) &&
    nibble_o == ($past(acc_o[3:0]) <= $past(rf_rdata_i[3:0])))
    else $error("subtract flags wrong");
  sub_borrow_a: assert property (take && op_i == BBS_OP_RSUBB && dest_i |=>
    rf_wdata_o == 8'($past(rf_rdata_i) - $past(acc_o) - {7'h00, !$past(borrow_o)}))
    else $error("subtract with borrow wrong");
  power_down_a: assert property (take && op_i == BBS_OP_SLEEP |=>
    wdt_count_o == 8'h00 && expiry_flag_o && !sleep_flag_o)
    else $error("power-down effects wrong");
  zero_flag_a: assert property (take && (op_i == BBS_OP_LSUB || op_i == BBS_OP_RSUB)
    && !dest_i |=> zero_o == (acc_o == 8'h00))
    else $error("zero flag wrong");

  skip_cov: cover property (take && op_i == BBS_OP_SKO && tbit);
  jump_cov: cover property (take && op_i == BBS_OP_RJMP && lit_i[8]);
  borrow_cov: cover property (take && op_i == BBS_OP_RSUBB && !borrow_o);
  sleep_cov: cover property (take && op_i == BBS_OP_SLEEP);
endmodule

// [verif/bbs_rf_model.sv]
/*
  data register file model facing the execution block: 128 bytes, read in
  the cycle of the instruction, written on the clock edge after a pulse.
  assumes one clock and no reset; contents start from a fixed pattern.
*/
`timescale 1ns/1ps

module bbs_rf_model (
  // clock
  input wire logic clk_i,
  // read side, qualified by the instruction valid
  input wire logic valid_i,
  input wire logic [6:0] addr_i,
  output logic [7:0] rdata_o,
  // write side from the core
  input wire logic we_i,
  input wire logic [6:0] waddr_i,
  input wire logic [7:0] wdata_i
);
  logic [7:0] mem [128]; // register contents

  ////////////////////////////////////////////////////////////////////////////
  // fixed start pattern so operands differ from one address to the next
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 8'h1d + 8'h07);
    end
  end

  // read data outside an instruction is inverted, so a core that samples
  // it at the wrong moment sees garbage rather than a lucky match
  assign rdata_o = valid_i ? mem[addr_i] : ~mem[addr_i];

  // write lands one edge after the pulse is presented
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end
endmodule

// [verif/tb.sv]
/*
  self-checking bench for the execution core: a table of instructions run
  against a reference model, then reset, refused-slot, watchdog cases.
  assumes the register file model and a 20 MHz clock.
*/
`timescale 1ns/1ps
`include "bbs_params.svh"
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end

module tb import bbs_pkg::*; ;
  // one row: instruction fields, then the accumulator and {c, dc, z} it should leave
  typedef struct {bbs_op_t op; logic [6:0] a; logic [2:0] b; logic d; logic [8:0] k;
    logic [7:0] xa; logic [2:0] xf;} bbs_row_t;
  logic clk = 1'h0, rst_n = 1'h0, valid = 1'h0, dest = 1'h0;
  bbs_op_t op = BBS_OP_IDLE;
  logic [6:0] faddr = 7'h00, waddr;
  logic [2:0] bitn = 3'h0;
  logic [8:0] lit = 9'h000;
  logic [7:0] rdata, wdata, acc, wdt, m_acc;
  logic [14:0] pc, m_pc;
  logic we, idle, c, dc, z, expf, slpf, m_c, m_dc, m_z;
  int n_fail = 0, checks = 0;
  // ordinary cases: arithmetic, bit ops, skips and jumps, odd opcode
  bbs_row_t rows [21] = '{
    '{BBS_OP_LSUB, 7'h00, 3'h0, 1'h0, 9'h000, 8'h00, 3'h7},
    '{BBS_OP_LSUB, 7'h00, 3'h0, 1'h0, 9'h05a, 8'h5a, 3'h6},
    '{BBS_OP_RSUB, 7'h03, 3'h0, 1'h1, 9'h000, 8'h5a, 3'h6},
    '{BBS_OP_RSUB, 7'h05, 3'h0, 1'h0, 9'h000, 8'h3e, 3'h4},
    '{BBS_OP_LSUB, 7'h00, 3'h0, 1'h0, 9'h000, 8'hc2, 3'h0},
    '{BBS_OP_RSUBB, 7'h04, 3'h0, 1'h0, 9'h000, 8'hb8, 3'h2},
    '{BBS_OP_RSUBB, 7'h09, 3'h0, 1'h1, 9'h000, 8'hb8, 3'h2},
    '{BBS_OP_RRC, 7'h06, 3'h0, 1'h1, 9'h000, 8'hb8, 3'h6},
    '{BBS_OP_RRC, 7'h07, 3'h0, 1'h0, 9'h000, 8'he9, 3'h2},
    '{BBS_OP_BCLR, 7'h08, 3'h7, 1'h0, 9'h000, 8'he9, 3'h2},
    '{BBS_OP_BSET, 7'h08, 3'h4, 1'h0, 9'h000, 8'he9, 3'h2},
    '{BBS_OP_SKZ, 7'h08, 3'h7, 1'h0, 9'h000, 8'he9, 3'h2},
    '{BBS_OP_SKZ, 7'h08, 3'h4, 1'h0, 9'h000, 8'he9, 3'h2},
    '{BBS_OP_SKO, 7'h08, 3'h4, 1'h0, 9'h000, 8'he9, 3'h2},
    '{BBS_OP_SKO, 7'h08, 3'h7, 1'h0, 9'h000, 8'he9, 3'h2},
    '{BBS_OP_RJMP, 7'h00, 3'h0, 1'h0, 9'h1f0, 8'he9, 3'h2},
    '{BBS_OP_RJMP, 7'h00, 3'h0, 1'h0, 9'h0ff, 8'he9, 3'h2},
    '{BBS_OP_RJMP, 7'h00, 3'h0, 1'h0, 9'h100, 8'he9, 3'h2},
    '{BBS_OP_AJMP, 7'h00, 3'h0, 1'h0, 9'h000, 8'he9, 3'h2},
    '{BBS_OP_IDLE, 7'h00, 3'h0, 1'h0, 9'h000, 8'he9, 3'h2},
    '{bbs_op_t'(12'h003), 7'h00, 3'h0, 1'h0, 9'h000, 8'he9, 3'h2}};

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  bbs_exec #(.PC_W(15), .PRE_W(2)) i_dut (.clk_i(clk), .rst_n_i(rst_n),
    .instr_valid_i(valid), .op_i(op), .faddr_i(faddr), .bit_i(bitn), .dest_i(dest),
    .lit_i(lit), .rf_rdata_i(rdata), .rf_we_o(we), .rf_addr_o(waddr), .rf_wdata_o(wdata),
    .pc_o(pc), .idle_slot_o(idle), .acc_o(acc), .borrow_o(c), .nibble_o(dc), .zero_o(z),
    .wdt_count_o(wdt), .expiry_flag_o(expf), .sleep_flag_o(slpf));
  bbs_rf_model i_rf (.clk_i(clk), .valid_i(valid), .addr_i(faddr), .rdata_o(rdata),
    .we_i(we), .waddr_i(waddr), .wdata_i(wdata));

  ////////////////////////////////////////////////////////////////////////////
  // one instruction: drive, predict after pending writes land, then check
  task automatic run(input bbs_row_t r);
    logic [7:0] f, res, wd;
    logic cin, ew, skip, jmp;
    @(posedge clk);
    op <= r.op; faddr <= r.a; bitn <= r.b; dest <= r.d; lit <= r.k; valid <= 1'h1;
    #1;
    f = i_rf.mem[r.a];
    wd = f; res = f; ew = 1'h0; skip = 1'h0; jmp = 1'h0;
    m_pc = m_pc + 15'h0001;
    case (r.op)
      BBS_OP_BCLR: begin ew = 1'h1; wd[r.b] = 1'h0; end
      BBS_OP_BSET: begin ew = 1'h1; wd[r.b] = 1'h1; end
      BBS_OP_SKZ: skip = !f[r.b];
      BBS_OP_SKO: skip = f[r.b];
      BBS_OP_RJMP: begin jmp = 1'h1; m_pc = m_pc + {{6{r.k[8]}}, r.k}; end
      BBS_OP_AJMP: begin jmp = 1'h1; m_pc = m_pc + {7'h00, m_acc}; end
      BBS_OP_RRC: begin res = {m_c, f[7:1]}; m_c = f[0]; end
      BBS_OP_LSUB, BBS_OP_RSUB, BBS_OP_RSUBB: begin
        if (r.op == BBS_OP_LSUB) f = r.k[7:0];
        cin = (r.op == BBS_OP_RSUBB) ? m_c : 1'h1;
        // borrow bits clear exactly when the subtrahend exceeds the operand
        res = 8'(f - m_acc - {7'h00, !cin});
        m_c = ({1'h0, f} >= {1'h0, m_acc} + {8'h00, !cin});
        m_dc = ({1'h0, f[3:0]} >= {1'h0, m_acc[3:0]} + {4'h0, !cin});
        m_z = (res == 8'h00);
      end
      default: ;
    endcase
    if (r.op inside {BBS_OP_RRC, BBS_OP_RSUB, BBS_OP_RSUBB}) begin
      if (r.d) begin ew = 1'h1; wd = res; end else m_acc = res;
    end
    if (r.op == BBS_OP_LSUB) m_acc = res;
    @(posedge clk);
    valid <= 1'h0;
    #1;
    `CHK("write strobe", ew, we)
    if (ew) `CHK("write", {r.a, wd}, {waddr, wdata})
    `CHK("acc", m_acc, acc)
    `CHK("flags", {m_c, m_dc, m_z}, {c, dc, z})
    `CHK("pc", m_pc, pc)
    `CHK("row acc and flags", {r.xa, r.xf}, {acc, c, dc, z})
    `CHK("idle slot", skip | jmp, idle)
    if (r.op == BBS_OP_SLEEP) `CHK("power", {8'h00, 2'h2}, {wdt, expf, slpf})
    if (skip | jmp) begin
      @(posedge clk);
      #1;
      if (skip) m_pc = m_pc + 15'h0001;
      `CHK("pc after slot", {m_pc, 1'h0}, {pc, idle})
    end
    $display("test op %0h done", r.op);
  endtask

  // model state after a reset
  task automatic model_reset;
    m_acc = 8'h00; m_c = 1'h0; m_dc = 1'h0; m_z = 1'h0; m_pc = 15'h0000;
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    model_reset;
    repeat (3) @(posedge clk);
    #1 `CHK("reset state", {15'h0000, 8'h00, 5'h03}, {pc, acc, c, dc, z, expf, slpf})
    $display("test reset done");
    @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    foreach (rows[i]) run(rows[i]);
    // instruction offered in the discarded slot must be ignored
    run('{BBS_OP_BCLR, 7'h0c, 3'h2, 1'h0, 9'h000, 8'he9, 3'h2});
    @(posedge clk);
    op <= BBS_OP_SKZ; faddr <= 7'h0c; bitn <= 3'h2; valid <= 1'h1;
    @(posedge clk);
    op <= BBS_OP_BSET;
    #1 `CHK("skip slot", 1'h1, idle)
    @(posedge clk);
    valid <= 1'h0;
    m_pc = m_pc + 15'h0002;
    #1 `CHK("ignored", {1'h0, m_pc}, {we, pc})
    $display("test discarded slot done");
    // let the watchdog expire, then power down clears it; a hang skips to the report
    for (int i = 0; i < 4000 && expf !== 1'h0; i++) begin
      @(posedge clk);
      #1;
    end
    if (expf !== 1'h0) begin
      n_fail++;
      $display("mismatch expiry expected 0 seen %0h", expf);
    end else begin
      run('{BBS_OP_SLEEP, 7'h00, 3'h0, 1'h0, 9'h000, 8'he9, 3'h2});
      // cleared 2-bit prescaler: the counter first steps four edges after power-down
      repeat (3) @(posedge clk);
      #1 `CHK("prescaler hold", 8'h00, wdt)
      @(posedge clk);
      #1 `CHK("prescaler wrap", 8'h01, wdt)
      $display("test power-down done");
      // second reset in mid-run acts at once, then the core runs again
      @(posedge clk);
      rst_n <= 1'h0;
      #1 `CHK("async reset", {8'h00, 2'h3}, {acc, expf, slpf})
      model_reset;
      @(posedge clk);
      rst_n <= 1'h1;
      repeat (2) @(posedge clk);
      run(rows[1]);
      $display("test mid-run reset done");
    end
    final_report;
  end
endmodule
